// [ccins_pkg.sv]
// Purpose: Shared constants and helpers of the caption inserter host port
// Assumes: Registers are 8 bits wide and addressed by an 8-bit pointer
// Notes:   Base line numbers and the serial address high bits are defaults

package ccins_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CC_FIRST  = 8'h20;
    localparam logic [7:0] REG_CC_SECOND = 8'h21;
    localparam logic [7:0] REG_CC_CTRL   = 8'h22;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_EN_BIT  = 7;
    localparam int CTRL_REQ_BIT = 6;
    localparam int CTRL_PAR_BIT = 5;
    localparam int CTRL_FLD_BIT = 4;
    localparam int CTRL_OFS_LSB = 0;
    localparam int OFS_W        = 4;

    // ------------------------------------------------------------------
    // Reset values and fixed codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] DATA_RST  = 8'h00;
    localparam logic [7:0] PTR_RST   = 8'h00;
    localparam logic [7:0] NULL_BYTE = 8'h80;
    localparam logic [9:0] BASE_LINE_ODD  = 10'h00a;
    localparam logic [9:0] BASE_LINE_EVEN = 10'h111;
    // Upper serial address bits, value arbitrary
    localparam logic [4:0] SLAVE_ADDR_HI  = 5'h0a;

    // Serial slave states
    typedef enum logic [2:0] {
        CCI_IDLE, CCI_RX, CCI_ACKW, CCI_TX, CCI_RACK
    } ccins_sstate_t;

    // Odd parity byte: parity in the top bit
    function automatic logic [7:0] odd_par(input logic [6:0] b);
        odd_par = {~^b, b};
    endfunction

endpackage

// [ccins_sync.sv]
// Purpose: Two-flop synchroniser for a bundle of pin inputs
// Assumes: Bits are independent levels
// Notes:   The first stage feeds only the second stage

`timescale 1ns/1ps
`default_nettype none

module ccins_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         srst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ccins_sync_t;

    ccins_sync_t st;
    ccins_sync_t next_st;

    // Shift stage
    always_comb begin
        next_st.s1 = d_in;
        next_st.s2 = st.s1;
    end

    // Registers
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q_out = st.s2;
endmodule

`default_nettype wire

// [ccins_twowire_slave.sv]
// Purpose: Two-wire serial slave reaching the shared register pointer
// Assumes: Clock and data pins already synchronised
// Notes:   Never drives the clock; data is pulled low only

`timescale 1ns/1ps
`default_nettype none

module ccins_twowire_slave
    import ccins_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       srst_in,
    input  wire logic       enable_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic [1:0] addr_lo_in,
    input  wire logic [7:0] rd_data_in,
    output logic            ptr_wr_out,
    output logic            reg_wr_out,
    output logic            reg_rd_out,
    output logic      [7:0] wdata_out,
    output logic            sda_oe_out
);
    typedef struct packed {
        ccins_sstate_t sm;
        logic [3:0]    cnt;
        logic [7:0]    sh;
        logic [1:0]    phase;  // 0 address, 1 register, 2 data
        logic          rd;
        logic          more;
        logic          scl_q;
        logic          sda_q;
        logic          oe;
        logic          ptr_wr;
        logic          reg_wr;
        logic          reg_rd;
    } ccins_slave_t;

    ccins_slave_t st;
    ccins_slave_t next_st;
    logic rise, fall, start, stop;

    // Bus events
    always_comb begin
        rise  = scl_in & ~st.scl_q;
        fall  = ~scl_in & st.scl_q;
        start = scl_in & st.scl_q & st.sda_q & ~sda_in;
        stop  = scl_in & st.scl_q & ~st.sda_q & sda_in;
    end

    // Byte engine
    always_comb begin
        next_st = st;
        next_st.scl_q  = scl_in;
        next_st.sda_q  = sda_in;
        next_st.ptr_wr = 1'b0;
        next_st.reg_wr = 1'b0;
        next_st.reg_rd = 1'b0;
        case (st.sm)
            CCI_RX: begin
                if (rise) begin
                    next_st.sh  = {st.sh[6:0], sda_in};
                    next_st.cnt = st.cnt + 4'h1;
                end else if (fall && st.cnt == 4'h8) begin
                    next_st.cnt = 4'h0;
                    next_st.sm  = CCI_IDLE;
                    if (st.phase == 2'h0 &&
                        st.sh[7:1] == {SLAVE_ADDR_HI, addr_lo_in}) begin
                        next_st.rd = st.sh[0];
                        next_st.oe = 1'b1;
                        next_st.sm = CCI_ACKW;
                    end else if (st.phase == 2'h1 && st.sh <= REG_CC_CTRL) begin
                        next_st.ptr_wr = 1'b1;
                        next_st.oe     = 1'b1;
                        next_st.sm     = CCI_ACKW;
                    end else if (st.phase == 2'h2) begin
                        next_st.reg_wr = 1'b1;
                        next_st.oe     = 1'b1;
                        next_st.sm     = CCI_ACKW;
                    end
                end
            end
            CCI_ACKW: begin
                if (fall) begin
                    if (st.rd && st.phase == 2'h0) begin
                        next_st.sh     = rd_data_in;
                        next_st.reg_rd = 1'b1;
                        next_st.oe     = ~rd_data_in[7];
                        next_st.sm     = CCI_TX;
                    end else begin
                        next_st.oe    = 1'b0;
                        next_st.phase = (st.phase == 2'h0) ? 2'h1 : 2'h2;
                        next_st.sm    = CCI_RX;
                    end
                end
            end
            CCI_TX: begin
                if (fall) begin
                    next_st.cnt = st.cnt + 4'h1;
                    next_st.sh  = {st.sh[6:0], 1'b0};
                    next_st.oe  = ~st.sh[6];
                    if (st.cnt == 4'h7) begin
                        next_st.oe   = 1'b0;
                        next_st.more = 1'b0;
                        next_st.sm   = CCI_RACK;
                    end
                end
            end
            CCI_RACK: begin
                if (rise) begin
                    next_st.more = ~sda_in;
                    next_st.sm   = sda_in ? CCI_IDLE : CCI_RACK;
                end else if (fall && st.more) begin
                    next_st.cnt    = 4'h0;
                    next_st.sh     = rd_data_in;
                    next_st.reg_rd = 1'b1;
                    next_st.oe     = ~rd_data_in[7];
                    next_st.sm     = CCI_TX;
                end
            end
            default: begin
                next_st.oe = 1'b0;
            end
        endcase
        if (!enable_in || stop) begin
            next_st.sm = CCI_IDLE;
            next_st.oe = 1'b0;
        end else if (start) begin
            next_st.sm    = CCI_RX;
            next_st.cnt   = 4'h0;
            next_st.phase = 2'h0;
            next_st.oe    = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ptr_wr_out = st.ptr_wr;
    assign reg_wr_out = st.reg_wr;
    assign reg_rd_out = st.reg_rd;
    assign wdata_out  = st.sh;
    assign sda_oe_out = st.oe;
endmodule

`default_nettype wire

// [ccins_host_port.sv]
// Purpose: Caption insertion engine with parallel and serial host access
// Assumes: Video timing arrives as same-clock signals; pins are async
// Notes:   Other encoder registers are not mapped here and read as zero
//
// Function
// - Caption on one line of sixteen, either field
// - Caption line overrides video and setup
// - Enabled caption replaces the selected line
// - Request high sends data, else null bytes
// - Target line is base plus offset
// - Auto parity makes odd parity, else raw
// - Control bit 6 shows transmission pending
// - Data at 20 and 21, control at 22
// - Transfer to processor clears send request
// - Data accesses advance pointer, control does not
// - Port select picks parallel or serial
// - Eight-bit bus, one address bit
// - Write data taken at strobe rise
// - Read drives bus while strobe low
// - Each port reaches all; own address
// - Serial side acts only as slave

`timescale 1ns/1ps
`default_nettype none

module ccins_host_port
    import ccins_pkg::*;
#(
    parameter int LINE_W = 10
) (
    input  wire logic              sys_clk_in,
    input  wire logic              srst_in,
    input  wire logic              port_select_in,
    input  wire logic              cs_scl_in,
    input  wire logic              sda_rw_in,
    output logic                   sda_rw_out,
    output logic                   sda_rw_oe_out,
    input  wire logic              addr_in,
    input  wire logic [1:0]        slave_addr_lo_in,
    input  wire logic [7:0]        host_data_bus_in,
    output logic      [7:0]        host_data_bus_out,
    output logic                   host_data_bus_oe_out,
    input  wire logic              line_start_in,
    input  wire logic              field_even_in,
    input  wire logic [LINE_W-1:0] line_num_in,
    input  wire logic              setup_prog_in,
    output logic                   caption_line_out,
    output logic      [15:0]       caption_data_out,
    output logic                   setup_en_out
);
    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (LINE_W < 10) begin : g_chk
        $error("LINE_W too small for the caption base lines");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  ptr;
        logic [7:0]  cc1;
        logic [7:0]  cc2;
        logic [7:0]  ctrl;
        logic        cs_q;
        logic        wr_act;
        logic        rd_act;
        logic        addr_l;
        logic [7:0]  dout;
        logic        doe;
        logic        sda_oe;
        logic        cap_line;
        logic [15:0] cap_data;
        logic        setup_en;
    } ccins_main_t;

    ccins_main_t st;
    ccins_main_t next_st;

    logic [13:0] sync_d;
    logic [13:0] sync_q;
    logic        ps_s, cs_s, rw_s, addr_s;
    logic [7:0]  data_s;
    logic [1:0]  sal_s;
    logic        s_ptr_wr, s_reg_wr, s_reg_rd, s_oe;
    logic [7:0]  s_wdata;
    logic [7:0]  rd_val;
    logic        cs_fall, cs_rise;
    logic        wr_en, ptr_ld, adv;
    logic [7:0]  wr_val, ptr_val;
    logic        match;
    logic [LINE_W-1:0] target;

    // Decoded register read
    function automatic logic [7:0] reg_read(input logic [7:0] p,
                                            input ccins_main_t s);
        case (p)
            REG_CC_FIRST:  reg_read = s.cc1;
            REG_CC_SECOND: reg_read = s.cc2;
            REG_CC_CTRL:   reg_read = s.ctrl;
            default:       reg_read = 8'h00;
        endcase
    endfunction

    // Caption byte after optional parity
    function automatic logic [7:0] cc_byte(input logic [7:0] b,
                                           input logic par);
        cc_byte = par ? odd_par(b[6:0]) : b;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers and serial slave
    // ------------------------------------------------------------------
    assign sync_d = {port_select_in, cs_scl_in, sda_rw_in, addr_in,
                     host_data_bus_in, slave_addr_lo_in};
    assign {ps_s, cs_s, rw_s, addr_s, data_s, sal_s} = sync_q;

    ccins_sync #(
        .W (14)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .d_in       (sync_d),
        .q_out      (sync_q)
    );

    ccins_twowire_slave u_serial (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .enable_in  (~ps_s),
        .scl_in     (cs_s),
        .sda_in     (rw_s),
        .addr_lo_in (sal_s),
        .rd_data_in (rd_val),
        .ptr_wr_out (s_ptr_wr),
        .reg_wr_out (s_reg_wr),
        .reg_rd_out (s_reg_rd),
        .wdata_out  (s_wdata),
        .sda_oe_out (s_oe)
    );

    // ------------------------------------------------------------------
    // Shared access decode
    // ------------------------------------------------------------------
    always_comb begin
        rd_val  = reg_read(st.ptr, st);
        cs_fall = st.cs_q & ~cs_s;
        cs_rise = ~st.cs_q & cs_s;
        ptr_ld  = (ps_s & cs_rise & st.wr_act & ~st.addr_l) | s_ptr_wr;
        wr_en   = (ps_s & cs_rise & st.wr_act & st.addr_l) | s_reg_wr;
        wr_val  = ps_s ? data_s : s_wdata;
        ptr_val = wr_val;
        adv     = (ps_s & cs_rise & st.addr_l & (st.wr_act | st.rd_act))
                | s_reg_wr | s_reg_rd;
    end

    // ------------------------------------------------------------------
    // Caption line match
    // ------------------------------------------------------------------
    always_comb begin
        target = (st.ctrl[CTRL_FLD_BIT] ? LINE_W'(BASE_LINE_EVEN)
                                        : LINE_W'(BASE_LINE_ODD))
               + LINE_W'(st.ctrl[CTRL_OFS_LSB +: OFS_W]);
        match  = st.ctrl[CTRL_EN_BIT]
               & (field_even_in == st.ctrl[CTRL_FLD_BIT])
               & (line_num_in == target);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.cs_q = cs_s;
        // Parallel strobe handling
        if (!ps_s) begin
            next_st.wr_act = 1'b0;
            next_st.rd_act = 1'b0;
            next_st.doe    = 1'b0;
        end else if (cs_fall) begin
            next_st.addr_l = addr_s;
            next_st.wr_act = ~rw_s;
            next_st.rd_act = rw_s;
            next_st.doe    = rw_s;
        end else if (cs_rise) begin
            next_st.wr_act = 1'b0;
            next_st.rd_act = 1'b0;
            next_st.doe    = 1'b0;
        end
        // Pointer or data on the bus
        if (next_st.rd_act) begin
            next_st.dout = next_st.addr_l ? rd_val : st.ptr;
        end
        // Serial pin drive only in serial mode
        next_st.sda_oe = s_oe & ~ps_s;

        if (ptr_ld) begin
            next_st.ptr = ptr_val;
        end else if (adv && (st.ptr == REG_CC_FIRST ||
                             st.ptr == REG_CC_SECOND)) begin
            next_st.ptr = st.ptr + 8'h01;
        end

        // Caption processor transfer at the line start
        if (line_start_in) begin
            next_st.cap_line = match;
            if (match) begin
                next_st.cap_data = st.ctrl[CTRL_REQ_BIT]
                    ? {cc_byte(st.cc2, st.ctrl[CTRL_PAR_BIT]),
                       cc_byte(st.cc1, st.ctrl[CTRL_PAR_BIT])}
                    : {NULL_BYTE, NULL_BYTE};
                next_st.ctrl[CTRL_REQ_BIT] = 1'b0;
            end
        end
        next_st.setup_en = setup_prog_in & ~next_st.cap_line;

        // Register writes; a host set wins over the clear
        if (wr_en) begin
            case (st.ptr)
                REG_CC_FIRST:  next_st.cc1  = wr_val;
                REG_CC_SECOND: next_st.cc2  = wr_val;
                REG_CC_CTRL:   next_st.ctrl = wr_val;
                default:       next_st.ctrl = next_st.ctrl;
            endcase
        end
    end

    // Registers
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st      <= '0;
            st.ptr  <= PTR_RST;
            st.cc1  <= DATA_RST;
            st.cc2  <= DATA_RST;
            st.ctrl <= CTRL_RST;
            st.cs_q <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state; serial data output tied low
    assign sda_rw_out           = 1'b0;
    assign sda_rw_oe_out        = st.sda_oe;
    assign host_data_bus_out    = st.dout;
    assign host_data_bus_oe_out = st.doe;
    assign caption_line_out     = st.cap_line;
    assign caption_data_out     = st.cap_data;
    assign setup_en_out         = st.setup_en;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Line replaced
    cap_line_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        line_start_in && match |=> caption_line_out)
        else $error("caption line not inserted");
    no_cap_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        line_start_in && !match |=> !caption_line_out)
        else $error("caption on an unselected line");
    null_bytes_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        line_start_in && match && !st.ctrl[CTRL_REQ_BIT]
        |=> caption_data_out == 16'h8080)
        else $error("null bytes wrong");
    auto_par_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        line_start_in && match && st.ctrl[CTRL_REQ_BIT]
        && st.ctrl[CTRL_PAR_BIT]
        |=> (^caption_data_out[7:0]) && (^caption_data_out[15:8]))
        else $error("parity not odd");
    raw_data_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        line_start_in && match && st.ctrl[CTRL_REQ_BIT]
        && !st.ctrl[CTRL_PAR_BIT]
        |=> caption_data_out == $past({st.cc2, st.cc1}))
        else $error("raw caption data altered");
    req_clear_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        line_start_in && match && !wr_en |=> !st.ctrl[CTRL_REQ_BIT])
        else $error("send request not cleared");
    setup_kill_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        caption_line_out |-> !setup_en_out)
        else $error("setup active on caption line");
    ptr_hold_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        adv && !ptr_ld && st.ptr == REG_CC_CTRL |=> $stable(st.ptr))
        else $error("pointer moved on control access");
    serial_quiet_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        ps_s |=> !sda_rw_oe_out)
        else $error("serial pin driven in parallel mode");
    par_drive_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        ps_s && cs_fall && rw_s ##1 ps_s && !cs_s |-> host_data_bus_oe_out)
        else $error("read data not driven");
endmodule

`default_nettype wire

// [ccins_host_model.sv]
// Purpose: Host controller driving the parallel and serial control ports
// Assumes: Strobe low and high phases of at least three cycles
// Notes:   Released data bus shows the inverse of its last value

`timescale 1ns/1ps
`default_nettype none

module ccins_host_model (
    input  wire logic       sys_clk_in,
    input  wire logic [7:0] rd_in,
    input  wire logic       oe_in,
    input  wire logic       sda_in,
    output logic            cs_n_out,
    output logic            rw_out,
    output logic            addr_out,
    output logic      [7:0] wd_out
);
    initial begin
        cs_n_out = 1'b1;
        rw_out   = 1'b1;
        addr_out = 1'b0;
        wd_out   = 8'h00;
    end

    task automatic cyc(input logic a, input logic rw, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge sys_clk_in);
        addr_out = a;
        rw_out   = rw;
        wd_out   = rw ? ~wd_out : d;
        cs_n_out = 1'b0;
        repeat (5) @(negedge sys_clk_in);
        q = oe_in ? rd_in : 8'hxx;
        cs_n_out = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        wd_out = ~wd_out;
    endtask

    // Serial start: data falls while the clock is high
    task automatic sstart();
        @(negedge sys_clk_in);
        rw_out = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        rw_out = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        cs_n_out = 1'b0;
    endtask

    // Serial bit: data changes one cycle after the clock falls
    task automatic sbit(input logic b);
        @(negedge sys_clk_in);
        rw_out = b;
        repeat (3) @(negedge sys_clk_in);
        cs_n_out = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        cs_n_out = 1'b0;
    endtask

    // Serial byte, MSB first, then the ninth clock with data released
    task automatic sbyte(input logic [7:0] b, output logic ack);
        for (int k = 7; k >= 0; k--) begin
            sbit(b[k]);
        end
        @(negedge sys_clk_in);
        rw_out = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        cs_n_out = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        ack = ~sda_in;
        repeat (2) @(negedge sys_clk_in);
        cs_n_out = 1'b0;
    endtask

    // Serial stop: data rises while the clock is high
    task automatic sstop();
        @(negedge sys_clk_in);
        rw_out = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        cs_n_out = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        rw_out = 1'b1;
        repeat (4) @(negedge sys_clk_in);
    endtask
endmodule

`default_nettype wire

// [closed_caption_inserter_host_port_tb.sv]
// Purpose: Self-checking bench of the caption inserter host port
// Assumes: Parallel port mainly; one serial write and one foreign address
// Notes:   Expected caption bytes are worked out here from the fields

`timescale 1ns/1ps
`default_nettype none

module closed_caption_inserter_host_port_tb
    import ccins_pkg::*;
;
    logic sys_clk, srst, psel, ls, fe, sp, cs, rw, ad, oe, cap, se;
    logic sda_oe, sda_do, sda_ln, ack;
    logic [9:0] ln;
    logic [7:0] wd, rd, q, d0, d1, ctl;
    logic [15:0] cd, ex;
    logic [31:0] lf;
    int n_fail, checked, cyc_cnt, i, oe_bad;

    // Open-drain serial data: low while the device pulls it
    assign sda_ln = rw & (sda_do | ~sda_oe);

    ccins_host_port dut (.sys_clk_in(sys_clk), .srst_in(srst),
        .port_select_in(psel), .cs_scl_in(cs), .sda_rw_in(sda_ln),
        .sda_rw_out(sda_do), .sda_rw_oe_out(sda_oe), .addr_in(ad),
        .slave_addr_lo_in(2'h1), .host_data_bus_in(wd),
        .host_data_bus_out(rd), .host_data_bus_oe_out(oe),
        .line_start_in(ls), .field_even_in(fe), .line_num_in(ln),
        .setup_prog_in(sp), .caption_line_out(cap),
        .caption_data_out(cd), .setup_en_out(se));

    ccins_host_model host (.sys_clk_in(sys_clk), .rd_in(rd), .oe_in(oe),
        .sda_in(sda_ln), .cs_n_out(cs), .rw_out(rw), .addr_out(ad),
        .wd_out(wd));

    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc_cnt++;
        // Parallel drivers must stay off in serial mode
        if (!psel && oe !== 1'b0)
            oe_bad++;
        if (cyc_cnt == 20000) begin
            n_fail++;
            conclude();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] oddp(input logic [7:0] b);
        oddp = {~^b[6:0], b[6:0]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One line start with the given field and line number
    task automatic line(input logic f, input logic [9:0] n);
        @(negedge sys_clk);
        fe = f;
        ln = n;
        ls = 1'b1;
        @(negedge sys_clk);
        ls = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic conclude();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        {psel, ls, fe, sp, ln} = {1'b1, 1'b0, 1'b0, 1'b1, 10'h000};
        lf = 32'hef04;
        srst = 1'b1;
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        host.cyc(1'b0, 1'b0, REG_CC_CTRL, q);
        host.cyc(1'b1, 1'b1, 8'h00, q);
        chk(q, CTRL_RST);
        for (i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            d0 = lf[7:0];
            d1 = lf[15:8];
            ctl = {2'b11, i[0], i[1], (i == 0) ? 4'h0 : lf[19:16] | {4{i[0]}}};
            host.cyc(1'b0, 1'b0, REG_CC_FIRST, q);
            host.cyc(1'b1, 1'b0, d0, q);
            host.cyc(1'b1, 1'b0, d1, q);
            host.cyc(1'b1, 1'b0, ctl, q);
            host.cyc(1'b1, 1'b1, 8'h00, q);
            chk(q, ctl);
            ex[9:0] = (i[1] ? BASE_LINE_EVEN : BASE_LINE_ODD) + ctl[3:0];
            line(~i[1], ex[9:0]);
            chk({cap, se}, 2'b01);
            line(i[1], ex[9:0]);
            ex = i[0] ? {oddp(d1), oddp(d0)} : {d1, d0};
            chk({cap, se}, 2'b10);
            chk(cd, ex);
            host.cyc(1'b1, 1'b1, 8'h00, q);
            chk(q, ctl & 8'hbf);
            line(i[1], (i[1] ? BASE_LINE_EVEN : BASE_LINE_ODD) + ctl[3:0]);
            chk(cd, {NULL_BYTE, NULL_BYTE});
        end
        host.cyc(1'b0, 1'b0, REG_CC_FIRST, q);
        host.cyc(1'b1, 1'b1, 8'h00, q);
        chk(q, d0);
        host.cyc(1'b1, 1'b1, 8'h00, q);
        chk(q, d1);
        host.cyc(1'b0, 1'b0, 8'h05, q);
        host.cyc(1'b1, 1'b1, 8'h00, q);
        chk(q, 8'h00);
        psel = 1'b0;
        host.cyc(1'b0, 1'b0, REG_CC_FIRST, q);
        host.cyc(1'b1, 1'b0, ~d0, q);
        host.cyc(1'b1, 1'b1, 8'h00, q);
        chk(16'(oe_bad), 16'h0000);
        // Serial master: a foreign address gets no acknowledge
        host.sstart();
        host.sbyte({SLAVE_ADDR_HI, 2'h2, 1'b0}, ack);
        chk(ack, 1'b0);
        host.sstop();
        host.sstart();
        host.sbyte({SLAVE_ADDR_HI, 2'h1, 1'b0}, ack);
        chk(ack, 1'b1);
        host.sbyte(REG_CC_SECOND, ack);
        chk(ack, 1'b1);
        host.sbyte(~d1, ack);
        chk(ack, 1'b1);
        host.sstop();
        psel = 1'b1;
        repeat (6) @(negedge sys_clk);
        host.cyc(1'b0, 1'b0, REG_CC_FIRST, q);
        host.cyc(1'b1, 1'b1, 8'h00, q);
        chk(q, d0);
        host.cyc(1'b1, 1'b1, 8'h00, q);
        chk(q, {8'h00, ~d1});
        conclude();
    end
endmodule

`default_nettype wire
